// File: src/prms_pkg.sv
// shared constants and types for the paired relay mirror supervisor
package prms_pkg;
  localparam int CLK_HZ         = 100_000_000;
  localparam int HB_DEFAULT_S   = 3600;
  localparam int LONG_PRESS_MS  = 5000;
  localparam int FLASH_MS       = 50;
  localparam int SLOW_HZ        = 1;
  localparam int FAST_HZ        = 2;
  localparam int SEC_CYC        = CLK_HZ;
  localparam int LONG_CYC       = LONG_PRESS_MS * (CLK_HZ / 1000);
  localparam int FLASH_CYC      = FLASH_MS * (CLK_HZ / 1000);
  localparam int SLOW_HALF_CYC  = CLK_HZ / (2 * SLOW_HZ);
  localparam int FAST_HALF_CYC  = CLK_HZ / (2 * FAST_HZ);
  localparam logic [3:0] OWN_REMOTE  = 4'h3;
  localparam logic [3:0] OWN_CTRL    = 4'hc;
  localparam logic [15:0] HB_RST     = 16'h0e10;
  localparam logic [7:0]  FB_MULT_RST = 8'h01;
  localparam logic [3:0]  DFLT_RST    = 4'h0;
  localparam logic [2:0]  RSSI_MAX    = 3'h5;

  typedef enum logic [1:0] {K_MIRROR, K_STATUS, K_RANGE, K_REPLY} prms_kind_t;
  typedef enum logic [1:0] {IND_R1, IND_R2, IND_IN, IND_RSV} prms_ind_t;
  typedef enum logic [1:0] {PS_NONE, PS_NORMAL, PS_LOW, PS_HIGH} prms_pwr_t;
endpackage : prms_pkg

// File: src/prms_led_if.sv
// indicator signals passed between the supervisor and the led driver
`timescale 1ns/1ps
interface prms_led_if;
  import prms_pkg::*;
  prms_pwr_t supply_st;
  prms_pwr_t batt_st;
  logic      rx_evt;
  logic      tx_evt;
  logic      power_led;
  logic      batt_led;
  logic      rx_led;
  logic      tx_led;
  modport ctl (output supply_st, batt_st, rx_evt, tx_evt,
               input power_led, batt_led, rx_led, tx_led);
  modport drv (input supply_st, batt_st, rx_evt, tx_evt,
               output power_led, batt_led, rx_led, tx_led);
endinterface : prms_led_if

// File: src/prms_led_drv.sv
// power, battery, rx and tx indicator driver
`timescale 1ns/1ps
module prms_led_drv
  import prms_pkg::*;
#(
  parameter int SLOW_HALF = SLOW_HALF_CYC,
  parameter int FAST_HALF = FAST_HALF_CYC,
  parameter int FLASH     = FLASH_CYC
) (
  input  wire logic clk_sys, // system clock
  input  wire logic rst_n,   // sync reset, active low
  prms_led_if.drv   led      // led signals
);
  logic [31:0] slow_cnt;
  logic [31:0] fast_cnt;
  logic        slow_ph;
  logic        fast_ph;
  logic [31:0] rx_cnt;
  logic [31:0] tx_cnt;

  function automatic logic led_of(input prms_pwr_t st, input logic slow, input logic fast);
    case (st)
      PS_NORMAL: led_of = 1'b1;
      PS_LOW:    led_of = slow;
      PS_HIGH:   led_of = fast;
      default:   led_of = 1'b0;
    endcase
  endfunction : led_of

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      slow_cnt <= '0;
      fast_cnt <= '0;
      slow_ph  <= 1'b0;
      fast_ph  <= 1'b0;
    end else begin
      slow_cnt <= (slow_cnt == 32'(SLOW_HALF - 1)) ? '0 : slow_cnt + 32'h0000_0001;
      fast_cnt <= (fast_cnt == 32'(FAST_HALF - 1)) ? '0 : fast_cnt + 32'h0000_0001;
      if (slow_cnt == 32'(SLOW_HALF - 1)) slow_ph <= !slow_ph;
      if (fast_cnt == 32'(FAST_HALF - 1)) fast_ph <= !fast_ph;
    end
  end

  // a fresh frame restarts the flash, so a burst shows as one long flash
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_cnt <= '0;
      tx_cnt <= '0;
    end else begin
      rx_cnt <= led.rx_evt ? 32'(FLASH) : (rx_cnt != 0 ? rx_cnt - 32'h0000_0001 : '0);
      tx_cnt <= led.tx_evt ? 32'(FLASH) : (tx_cnt != 0 ? tx_cnt - 32'h0000_0001 : '0);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      led.power_led <= 1'b0;
      led.batt_led  <= 1'b0;
      led.rx_led    <= 1'b0;
      led.tx_led    <= 1'b0;
    end else begin
      led.power_led <= led_of(led.supply_st, slow_ph, fast_ph);
      led.batt_led  <= led_of(led.batt_st, slow_ph, fast_ph);
      led.rx_led    <= led.rx_evt || rx_cnt > 32'h0000_0001;
      led.tx_led    <= led.tx_evt || tx_cnt > 32'h0000_0001;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  rx_flash_a: assert property (led.rx_evt |=> led.rx_led)
    else $error("rx led missed a frame");
  pwr_steady_a: assert property (led.supply_st == PS_NORMAL |=> led.power_led)
    else $error("power led not steady on normal supply");
  batt_off_a: assert property (led.batt_st == PS_NONE |=> !led.batt_led)
    else $error("battery led lit with no battery");
endmodule : prms_led_drv

// File: src/prms_supervisor.sv
// paired relay mirror supervisor: link watch, relay mirror, button, indicators
`timescale 1ns/1ps
module prms_supervisor
  import prms_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYC,
  parameter int LONG_CYCLES = LONG_CYC,
  parameter int SLOW_HALF  = SLOW_HALF_CYC,
  parameter int FAST_HALF  = FAST_HALF_CYC,
  parameter int FLASH      = FLASH_CYC
) (
  input  wire logic       clk_sys,             // system clock
  input  wire logic       rst_n,               // sync reset, active low
  input  wire logic       is_remote,           // 1 remote unit, 0 controller unit
  input  wire logic [3:0] relay_control_input_n, // control inputs, active low
  input  wire logic       aux_in_n,            // aux input, active low
  input  wire logic       ind_in_n,            // indicator input, active low
  input  wire logic       test_button_n,       // test button, active low
  input  wire logic       cfg_mode_clr,        // leave configuration mode
  input  wire logic       cfg_we,              // load settings below
  input  wire logic [15:0] cfg_hb_s,           // heartbeat in seconds
  input  wire logic       cfg_fb_en,           // fallback enable
  input  wire logic [7:0] cfg_fb_mult,         // fallback after n heartbeats
  input  wire logic [3:0] cfg_rly_dflt,        // fallback relay states
  input  wire logic [1:0] cfg_ind_src,         // indicator source
  input  wire logic [1:0] supply_status,       // supply level class
  input  wire logic [1:0] battery_status,      // battery level class
  input  wire logic       rx_valid,            // frame received, pulse
  input  wire logic [1:0] rx_kind,             // received frame kind
  input  wire logic [3:0] rx_ctl,              // partner inputs, active high
  input  wire logic       rx_aux,              // partner aux, active high
  input  wire logic       rx_ind,              // partner indicator, active high
  input  wire logic [2:0] rx_rssi,             // received strength 0..5
  output logic            tx_valid,            // frame offered to radio
  input  wire logic       tx_ready,            // radio takes frame
  input  wire logic       tx_done,             // partner acknowledged, pulse
  output logic [1:0]      tx_kind,             // offered frame kind
  output logic [3:0]      tx_ctl,              // local inputs, active high
  output logic            tx_aux,              // local aux, active high
  output logic            tx_ind,              // local indicator, active high
  output logic [3:0]      relay_out,           // relay coils, high energised
  output logic            aux_out,             // aux output level
  output logic            ind_out,             // reader indicator level
  output logic [5:0]      strength_led,        // strength bar
  output logic            power_led,           // supply indicator
  output logic            battery_led,         // battery indicator
  output logic            rx_led,              // receive indicator
  output logic            tx_led,              // transmit indicator
  output logic            cfg_mode,            // configuration mode
  output logic            link_ok,             // no status exchange outstanding
  output logic            mirror_mismatch,     // last exchange disagreed
  output logic            in_fallback          // relays at defaults
);
  prms_led_if led ();

  logic [15:0] hb_s;
  logic        fb_en;
  logic [7:0]  fb_mult;
  logic [3:0]  rly_dflt;
  prms_ind_t   ind_src;
  logic [3:0]  relay;
  logic        par_aux;
  logic        par_ind;
  logic [31:0] sec_cnt;
  logic [15:0] hb_cnt;
  logic [7:0]  silent;
  logic        st_req;
  logic        st_wait;
  logic        reply_req;
  logic        range_req;
  logic        range_wait;
  logic [31:0] btn_cnt;
  logic [5:0]  last_sent;
  logic [5:0]  bar;

  function automatic logic [5:0] bar_of(input logic [2:0] r);
    logic [2:0] n;
    n = (r > RSSI_MAX) ? RSSI_MAX : r;
    bar_of = 6'h3f >> (RSSI_MAX - n);
  endfunction : bar_of

  // decode
  wire [3:0]  own       = is_remote ? OWN_REMOTE : OWN_CTRL;
  wire [3:0]  loc_ctl   = ~relay_control_input_n;
  wire [5:0]  loc_state = {loc_ctl, ~aux_in_n, ~ind_in_n};
  wire        traffic   = rx_valid || tx_done;
  wire        sec_tick  = sec_cnt == 32'(SEC_CYCLES - 1);
  wire        hb_hit    = sec_tick && (17'(hb_cnt) + 17'h0_0001 >= 17'(hb_s)) && !traffic;
  wire        fb_hit    = fb_en && hb_hit && fb_mult != 8'h00
                          && (9'(silent) + 9'h001 >= 9'(fb_mult));
  wire        rx_kind_m = rx_kind == K_MIRROR;
  wire        rx_stat   = rx_kind == K_STATUS || rx_kind == K_REPLY;
  wire        rx_apply  = rx_valid && (rx_kind_m || rx_stat);
  wire        rx_ask    = rx_valid && (rx_kind == K_STATUS || rx_kind == K_RANGE);
  wire        rx_reply  = rx_valid && rx_kind == K_REPLY;
  wire        mirror_need = loc_state != last_sent;
  wire        pressed   = !test_button_n;
  wire        short_rel = !pressed && btn_cnt != 0 && btn_cnt < 32'(LONG_CYCLES);
  wire        long_hit  = pressed && btn_cnt == 32'(LONG_CYCLES - 1);
  wire        take      = !tx_valid && (reply_req || mirror_need || st_req || range_req);
  wire        sent      = tx_valid && tx_ready;
  wire        ind_act   = ind_src == IND_R2 ? relay[1] :
                          ind_src == IND_IN ? par_ind : relay[0];

  prms_kind_t next_kind;
  always_comb begin
    if (reply_req)        next_kind = K_REPLY;
    else if (mirror_need) next_kind = K_MIRROR;
    else if (st_req)      next_kind = K_STATUS;
    else                  next_kind = K_RANGE;
  end

  // settings change only the stored copy; relays move on their next event
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hb_s     <= HB_RST;
      fb_en    <= 1'b0;
      fb_mult  <= FB_MULT_RST;
      rly_dflt <= DFLT_RST;
      ind_src  <= IND_R1;
    end else if (cfg_we) begin
      hb_s     <= cfg_hb_s;
      fb_en    <= cfg_fb_en;
      fb_mult  <= cfg_fb_mult;
      rly_dflt <= cfg_rly_dflt;
      ind_src  <= prms_ind_t'(cfg_ind_src);
    end
  end

  // heartbeat: seconds prescaler, interval and silence counters
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sec_cnt <= '0;
      hb_cnt  <= '0;
      silent  <= '0;
    end else if (traffic) begin
      sec_cnt <= '0;
      hb_cnt  <= '0;
      silent  <= '0;
    end else if (sec_tick) begin
      sec_cnt <= '0;
      hb_cnt  <= hb_hit ? '0 : hb_cnt + 16'h0001;
      if (hb_hit && silent != 8'hff) silent <= silent + 8'h01;
    end else begin
      sec_cnt <= sec_cnt + 32'h0000_0001;
    end
  end

  // exchange bookkeeping; a set in the clearing cycle wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_req     <= 1'b0;
      st_wait    <= 1'b0;
      reply_req  <= 1'b0;
      range_req  <= 1'b0;
      range_wait <= 1'b0;
    end else begin
      st_req    <= hb_hit || (st_req && !(take && next_kind == K_STATUS));
      st_wait   <= hb_hit || (st_wait && !(rx_valid && rx_stat));
      reply_req <= rx_ask || (reply_req && !(take && next_kind == K_REPLY));
      range_req <= short_rel || (range_req && !(take && next_kind == K_RANGE));
      range_wait <= (take && next_kind == K_RANGE) || (range_wait && !rx_reply);
    end
  end

  // relay mirror and fallback; no other path moves a relay
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      relay       <= '0;
      par_aux     <= 1'b0;
      par_ind     <= 1'b0;
      in_fallback <= 1'b0;
      mirror_mismatch <= 1'b0;
    end else if (rx_apply) begin
      relay       <= (relay & ~own) | (rx_ctl & own);
      par_aux     <= rx_aux;
      par_ind     <= rx_ind;
      in_fallback <= 1'b0;
      if (rx_stat) mirror_mismatch <= (relay & own) != (rx_ctl & own);
    end else if (fb_hit) begin
      relay       <= (relay & ~own) | (rly_dflt & own);
      in_fallback <= 1'b1;
    end
  end

  // frame offer towards the radio, held until taken
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_valid  <= 1'b0;
      tx_kind   <= K_MIRROR;
      tx_ctl    <= '0;
      tx_aux    <= 1'b0;
      tx_ind    <= 1'b0;
      last_sent <= '0;
    end else if (take) begin
      tx_valid  <= 1'b1;
      tx_kind   <= next_kind;
      {tx_ctl, tx_aux, tx_ind} <= loc_state;
      last_sent <= loc_state;
    end else if (sent) begin
      tx_valid  <= 1'b0;
    end
  end

  // test button: short release starts range test, long hold enters config
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      btn_cnt  <= '0;
      cfg_mode <= 1'b0;
    end else begin
      if (!pressed) btn_cnt <= '0;
      else if (btn_cnt < 32'(LONG_CYCLES)) btn_cnt <= btn_cnt + 32'h0000_0001;
      if (long_hit) cfg_mode <= 1'b1;
      else if (cfg_mode_clr) cfg_mode <= 1'b0;
    end
  end

  // strength bar holds the last range reply until the next one
  always_ff @(posedge clk_sys) begin
    if (!rst_n) bar <= '0;
    else if (rx_reply && range_wait) bar <= bar_of(rx_rssi);
  end

  // output levels registered so they never glitch on a mux change
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      aux_out <= 1'b1;
      ind_out <= 1'b1;
    end else begin
      aux_out <= is_remote ? 1'b1 : !par_aux;
      ind_out <= is_remote ? !ind_act : 1'b1;
    end
  end

  assign relay_out    = relay & own;
  assign strength_led = bar;
  assign link_ok      = !st_wait;

  assign led.supply_st = prms_pwr_t'(supply_status);
  assign led.batt_st   = prms_pwr_t'(battery_status);
  assign led.rx_evt    = rx_valid;
  assign led.tx_evt    = sent;
  assign power_led     = led.power_led;
  assign battery_led   = led.batt_led;
  assign rx_led        = led.rx_led;
  assign tx_led        = led.tx_led;

  prms_led_drv #(
    .SLOW_HALF (SLOW_HALF),
    .FAST_HALF (FAST_HALF),
    .FLASH     (FLASH)
  ) u_led (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .led     (led.drv)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  hb_start_a: assert property (hb_hit |=> st_req && st_wait)
    else $error("heartbeat lapse did not start exchange");

  hb_restart_a: assert property (traffic |=> hb_cnt == 0 && sec_cnt == 0 && silent == 0)
    else $error("traffic did not restart heartbeat");

  exch_close_a: assert property (rx_reply |=> link_ok)
    else $error("reply did not close exchange");

  relay_hold_a: assert property (!rx_apply && !fb_hit |=> relay_out == $past(relay_out))
    else $error("relay moved without command or fallback");

  fb_enter_a: assert property (fb_hit && !rx_apply |=> in_fallback
                               && relay_out == ($past(rly_dflt) & own))
    else $error("fallback did not apply defaults");

  fb_off_a: assert property (!fb_en && !in_fallback |=> !in_fallback)
    else $error("fallback fired while disabled");

  fb_stay_a: assert property (in_fallback && !rx_apply |=> in_fallback)
    else $error("fallback left without command");

  mirror_a: assert property (rx_apply |=> relay_out == ($past(rx_ctl) & own))
    else $error("relay does not follow partner input");

  ind_lvl_a: assert property (is_remote && $stable(is_remote) |=> ind_out == !$past(ind_act))
    else $error("indicator level wrong");

  aux_lvl_a: assert property (!is_remote && !rx_apply ##1 !is_remote |-> aux_out == !par_aux)
    else $error("aux output wrong");

  aux_idle_a: assert property (is_remote && $stable(is_remote) |=> aux_out)
    else $error("remote aux output not idle high");

  range_go_a: assert property (short_rel |=> range_req ##[0:3] tx_valid)
    else $error("short press did not start range test");

  cfg_hold_a: assert property (long_hit |=> cfg_mode && !range_req)
    else $error("long hold did not enter config mode");

  short_cfg_a: assert property (short_rel && !cfg_mode |=> !cfg_mode)
    else $error("short press entered config mode");

  tx_hold_a: assert property (tx_valid && !tx_ready
                              |=> tx_valid && $stable(tx_kind) && $stable(tx_ctl))
    else $error("offered frame changed before it was taken");

  bar_shape_a: assert property (bar == 6'h00 || (bar[0] && ((bar + 6'h01) & bar) == 6'h00))
    else $error("strength bar not a thermometer");

  bar_min_a: assert property (rx_reply && range_wait && rx_rssi == 3'h0
                              |=> strength_led == 6'h01)
    else $error("weakest reply did not light one led");

  bar_max_a: assert property (rx_reply && range_wait && rx_rssi >= RSSI_MAX
                              |=> strength_led == 6'h3f)
    else $error("strongest reply did not light six leds");

  fb_seen_c: cover property (fb_hit ##1 in_fallback ##[1:50] rx_apply);
  range_seen_c: cover property (range_wait ##[1:50] rx_reply);
  cfg_seen_c: cover property (long_hit ##1 cfg_mode);
  mismatch_seen_c: cover property (rx_valid && rx_stat ##1 mirror_mismatch);
  reply_seen_c: cover property (take && next_kind == K_REPLY);
endmodule : prms_supervisor

// File: verification/prms_partner.sv
// behavioural model of the paired unit across the radio link
`timescale 1ns/1ps
module prms_partner
  import prms_pkg::*;
(
  input  wire logic       clk_sys,  // system clock
  input  wire logic       mute,     // take frames, never ack or answer
  input  wire logic       slow,     // stall before taking a frame
  input  wire logic [3:0] p_ctl,    // own inputs, active high
  input  wire logic [2:0] rssi,     // strength put in replies
  input  wire logic       tx_valid, // frame offered
  input  wire logic [1:0] tx_kind,  // offered kind
  input  wire logic [3:0] tx_ctl,   // offered inputs
  output logic            tx_ready, // frame taken
  output logic            tx_done,  // ack pulse
  output logic            rx_valid, // frame pulse
  output logic [1:0]      rx_kind,  // frame kind
  output logic [3:0]      rx_ctl,   // inputs, active high
  output logic            rx_aux,   // aux, active high
  output logic            rx_ind,   // indicator, active high
  output logic [2:0]      rx_rssi   // strength
);
  logic [1:0]  last_kind = 2'h0;
  logic [3:0]  last_ctl = 4'h0;
  logic [10:0] q[$];
  int          n_frames = 0;
  int          n_seen = 0;
  int          stall = 0;
  initial begin
    {tx_ready, tx_done, rx_valid, rx_kind, rx_ctl, rx_aux, rx_ind, rx_rssi} = '0;
  end
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) begin
      last_kind <= tx_kind;
      last_ctl  <= tx_ctl;
      n_frames  <= n_frames + 1;
    end
  end
  // everything the far side drives changes on the falling edge
  always @(negedge clk_sys) begin
    tx_done = 1'b0;
    if (n_seen != n_frames) begin
      n_seen = n_frames;
      tx_ready = 1'b0;
      stall = 0;
      if (!mute) begin
        tx_done = 1'b1;
        if (last_kind inside {K_STATUS, K_RANGE}) q.push_back({K_REPLY, p_ctl, 2'h0, rssi});
      end
    end else if (tx_valid) begin
      if (stall >= (slow ? 6 : 0)) tx_ready = 1'b1;
      else stall++;
    end
    if (rx_valid) rx_valid = 1'b0;
    else if (q.size() > 0) begin
      {rx_kind, rx_ctl, rx_aux, rx_ind, rx_rssi} = q.pop_front();
      rx_valid = 1'b1;
    end
    // released lines flip on every falling edge, showing the last value every other cycle
    if (!rx_valid) {rx_ctl, rx_aux, rx_ind, rx_rssi} = ~{rx_ctl, rx_aux, rx_ind, rx_rssi};
  end
endmodule : prms_partner

// File: verification/paired_relay_mirror_supervisor_tb.sv
// self-checking bench for the paired relay mirror supervisor
`timescale 1ns/1ps
module paired_relay_mirror_supervisor_tb;
  import prms_pkg::*;
  localparam int SEC = 10;
  localparam int LONG = 20;
  logic clk_sys = 1'b0, rst_n = 1'b0, is_remote = 1'b1, aux_n = 1'b1, ind_n = 1'b1;
  logic btn_n = 1'b1, cfg_clr = 1'b0, cfg_we = 1'b0, fb_en = 1'b0, mute = 1'b0, slow = 1'b0;
  logic [15:0] hb = HB_RST;
  logic [7:0]  mult = FB_MULT_RST;
  logic [3:0]  ctl_n = 4'hf, dflt = 4'h0, p_ctl = 4'h0, relay_out, tx_ctl, rx_ctl, leds;
  logic [1:0]  src = 2'h0, sup = 2'h1, bat = 2'h1, rx_kind, tx_kind;
  logic [2:0]  rssi = 3'h0, rx_rssi;
  logic [5:0]  strength_led;
  logic tx_valid, tx_ready, tx_done, rx_valid, rx_aux, rx_ind, aux_out, ind_out, tx_aux, tx_ind;
  logic power_led, battery_led, rx_led, tx_led, cfg_mode, link_ok, mm, in_fallback;
  logic [31:0] lfsr = 32'h0000_e2e1;
  int errors = 0;
  int check_count = 0;
  assign leds = {battery_led, power_led, tx_led, rx_led};
  always #5 clk_sys = ~clk_sys;
  prms_supervisor #(.SEC_CYCLES(SEC), .LONG_CYCLES(LONG), .SLOW_HALF(8), .FAST_HALF(4),
    .FLASH(3)) u_prms_supervisor (.clk_sys, .rst_n, .is_remote,
    .relay_control_input_n(ctl_n), .aux_in_n(aux_n), .ind_in_n(ind_n), .test_button_n(btn_n),
    .cfg_mode_clr(cfg_clr), .cfg_we, .cfg_hb_s(hb), .cfg_fb_en(fb_en), .cfg_fb_mult(mult),
    .cfg_rly_dflt(dflt), .cfg_ind_src(src), .supply_status(sup), .battery_status(bat),
    .rx_valid, .rx_kind, .rx_ctl, .rx_aux, .rx_ind, .rx_rssi, .tx_valid, .tx_ready, .tx_done,
    .tx_kind, .tx_ctl, .tx_aux, .tx_ind, .relay_out, .aux_out, .ind_out, .strength_led,
    .power_led, .battery_led, .rx_led, .tx_led, .cfg_mode, .link_ok, .mirror_mismatch(mm),
    .in_fallback);
  prms_partner u_prms_partner (.clk_sys, .mute, .slow, .p_ctl, .rssi, .tx_valid, .tx_kind,
    .tx_ctl, .tx_ready, .tx_done, .rx_valid, .rx_kind, .rx_ctl, .rx_aux, .rx_ind, .rx_rssi);
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  function automatic logic [7:0] exp_led(input logic [1:0] st, input logic want_hi);
    if (want_hi) return st == PS_NORMAL ? 8'h20 : st[1] ? 8'h10 : 8'h00;
    return st[1] ? (st[0] ? 8'h08 : 8'h04) : 8'h00;
  endfunction : exp_led
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  task automatic send(input logic [1:0] k, input logic [3:0] c, input logic a, input logic i);
    u_prms_partner.q.push_back({k, c, a, i, 3'h0});
    tick(5);
  endtask : send
  task automatic cfg(input logic [1:0] s);
    src = s;
    cfg_we = 1'b1;
    tick(1);
    cfg_we = 1'b0;
    tick(1);
  endtask : cfg
  task automatic watch(input int sel, input int n, output logic [7:0] hi, output logic [7:0] fl);
    logic p;
    hi = 8'h00;
    fl = 8'h00;
    p = leds[sel];
    for (int k = 0; k < n; k++) begin
      tick(1);
      hi += leds[sel];
      fl += (leds[sel] != p);
      p = leds[sel];
    end
  endtask : watch
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    logic [7:0] hi, fl;
    logic [3:0] c;
    logic [31:0] r;
    int n0;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys) rst_n = 1'b1;
    tick(1);
    chk("relay_out", 8'h00, relay_out);
    chk("ind_out", 8'h01, ind_out);
    chk("link_ok", 8'h01, link_ok);
    chk("in_fallback", 8'h00, in_fallback);
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      send(K_MIRROR, r[3:0], r[4], r[5]);
      chk("relay_out", r[3:0] & OWN_REMOTE, relay_out);
      chk("ind_out", !r[0], ind_out);
    end
    for (int s = 0; s < 4; s++) begin
      c = relay_out;
      cfg(s[1:0]);
      chk("relay_out", c, relay_out);
      r = rnd();
      send(K_MIRROR, r[3:0], 1'b0, r[5]);
      chk("ind_out", !(s == 1 ? r[1] : s == 2 ? r[5] : r[0]), ind_out);
    end
    cfg(2'h0);
    u_prms_partner.q.push_back({K_MIRROR, 4'h0, 2'h0, 3'h0});
    watch(0, 12, hi, fl);
    chk("rx_led", 8'h03, hi);
    for (int k = 0; k < 4; k++) begin
      slow = k[0];
      r = rnd();
      ctl_n = ctl_n ^ (r[3:0] | 4'h1);
      aux_n = r[4];
      ind_n = r[5];
      watch(1, 20, hi, fl);
      chk("tx_led", 8'h03, hi);
      chk("tx_kind", K_MIRROR, u_prms_partner.last_kind);
      chk("tx_ctl", 4'(~ctl_n), u_prms_partner.last_ctl);
      chk("tx_aux_ind", {6'h00, ~aux_n, ~ind_n}, {6'h00, tx_aux, tx_ind});
    end
    for (int k = 0; k < 6; k++) begin
      rssi = k[2:0];
      btn_n = 1'b0;
      tick(4);
      btn_n = 1'b1;
      tick(20);
      chk("range_kind", K_RANGE, u_prms_partner.last_kind);
      chk("strength_led", 6'h3f >> (3'h5 - rssi), strength_led);
    end
    // an answer nobody asked for leaves the bar alone
    u_prms_partner.q.push_back({K_REPLY, 4'h0, 2'h0, 3'h0});
    tick(6);
    chk("strength_led", 8'h3f, strength_led);
    n0 = u_prms_partner.n_frames;
    btn_n = 1'b0;
    tick(LONG - 3);
    chk("cfg_mode", 8'h00, cfg_mode);
    tick(6);
    chk("cfg_mode", 8'h01, cfg_mode);
    btn_n = 1'b1;
    tick(10);
    chk("range_sent", 8'h00, 8'(u_prms_partner.n_frames - n0));
    cfg_clr = 1'b1;
    tick(1);
    cfg_clr = 1'b0;
    tick(1);
    chk("cfg_mode", 8'h00, cfg_mode);
    for (int k = 0; k < 4; k++) begin
      sup = k[1:0];
      bat = 2'(3 - k);
      tick(40);
      watch(2, 32, hi, fl);
      chk("power_on", exp_led(sup, 1'b1), hi);
      chk("power_flips", exp_led(sup, 1'b0), fl);
      watch(3, 32, hi, fl);
      chk("battery_on", exp_led(bat, 1'b1), hi);
      chk("battery_flips", exp_led(bat, 1'b0), fl);
    end
    mute = 1'b1;
    send(K_MIRROR, 4'h1, 1'b0, 1'b0);
    hb = 16'h0002;
    cfg(2'h0);
    for (int k = 0; k < 8; k++) begin
      send(K_MIRROR, 4'h1, 1'b0, 1'b0);
      tick(3);
      chk("link_ok", 8'h01, link_ok);
    end
    c = relay_out;
    n0 = u_prms_partner.n_frames;
    for (int k = 0; k < 45 && link_ok !== 1'b0; k++) tick(1);
    tick(10);
    chk("link_ok", 8'h00, link_ok);
    chk("status_kind", K_STATUS, u_prms_partner.last_kind);
    tick(70);
    chk("relay_out", c, relay_out);
    chk("retries", 8'h01, {7'h00, u_prms_partner.n_frames - n0 >= 3});
    p_ctl = ~c;
    mute = 1'b0;
    for (int k = 0; k < 45 && link_ok !== 1'b1; k++) tick(1);
    tick(3);
    chk("link_ok", 8'h01, link_ok);
    chk("mismatch", 8'h01, mm);
    chk("relay_out", (~c) & OWN_REMOTE, relay_out);
    tick(40);
    chk("mismatch", 8'h00, mm);
    r = rnd();
    dflt = r[3:0];
    fb_en = 1'b1;
    mult = 8'h02;
    hb = 16'h0001;
    mute = 1'b1;
    cfg(2'h0);
    for (int k = 0; k < 40 && link_ok !== 1'b0; k++) tick(1);
    chk("in_fallback", 8'h00, in_fallback);
    for (int k = 0; k < 80 && in_fallback !== 1'b1; k++) tick(1);
    tick(2);
    chk("relay_out", dflt & OWN_REMOTE, relay_out);
    tick(30);
    chk("relay_out", dflt & OWN_REMOTE, relay_out);
    p_ctl = ~dflt;
    mute = 1'b0;
    send(K_MIRROR, ~dflt, 1'b0, 1'b0);
    chk("in_fallback", 8'h00, in_fallback);
    chk("relay_out", (~dflt) & OWN_REMOTE, relay_out);
    rst_n = 1'b0;
    is_remote = 1'b0;
    tick(3);
    rst_n = 1'b1;
    tick(2);
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      send(K_MIRROR, r[3:0], r[4], r[5]);
      chk("relay_out", r[3:0] & OWN_CTRL, relay_out);
      chk("aux_out", !r[4], aux_out);
      chk("ind_out", 8'h01, ind_out);
    end
    send(K_STATUS, 4'h0, 1'b0, 1'b0);
    tick(10);
    chk("reply_kind", K_REPLY, u_prms_partner.last_kind);
    tally_and_finish();
  end
  initial begin
    repeat (10000) @(posedge clk_sys);
    errors++;
    $display("watchdog expired before the tests ended");
    tally_and_finish();
  end
endmodule : paired_relay_mirror_supervisor_tb
